// File: hdl/stcw_cfg.svh
`ifndef STCW_CFG_SVH
`define STCW_CFG_SVH

// system clock rate and the 1 ms tick period
`define STCW_CLK_MHZ      32'h0000_00C8
`define STCW_MS_US        32'h0000_03E8
// last count of the divide-by-10 stepping the 10 ms and 100 ms bases (from the finer base)
`define STCW_TB_DIV       4'h9
// supply dip tolerated, ms
`define STCW_DIP_MAX_MS   4'hA
// watchdog preset, in 10 ms steps: 10 ms .. 6000 ms
`define STCW_WDT_STEP_MS  13'h000A
`define STCW_WDT_MIN      10'h001
`define STCW_WDT_MAX      10'h258
// first timer numbers of the 10 ms and 1 ms bases
`define STCW_FIRST_10MS   32'h0000_00C0
`define STCW_FIRST_1MS    32'h0000_00FB
// bank sizes
`define STCW_NUM_TMR      32'h0000_0100
`define STCW_NUM_CNT      32'h0000_0100
// scan statistics reset values
`define STCW_MIN_INIT     16'hFFFF

`endif

// File: hdl/stcw_pkg.sv
package stcw_pkg;

  typedef enum logic [2:0] {
    ON_DELAY_TIMER,
    OFF_DELAY_TIMER,
    ACCUMULATING_TIMER,
    ONE_SHOT_TIMER,
    RETRIGGER_TIMER
  } timer_mode_e;

  typedef enum logic [1:0] {
    UP_COUNTER,
    DOWN_COUNTER,
    BIDIRECTIONAL_COUNTER,
    RING_COUNTER
  } counter_mode_e;

  typedef enum logic [1:0] {
    TB_100MS,
    TB_10MS,
    TB_1MS
  } time_base_e;

endpackage

// File: hdl/scan_timer_counter_watchdog.sv
`include "stcw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module scan_timer_counter_watchdog #(
  parameter int NUM_TMR    = `STCW_NUM_TMR,
  parameter int NUM_CNT    = `STCW_NUM_CNT,
  parameter int CYC_PER_MS = `STCW_CLK_MHZ * `STCW_MS_US
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_power_ok,
  input  wire logic                 i_restart,
  input  wire logic                 i_mode_stop,
  input  wire logic                 i_scan_start,
  input  wire logic                 i_wdt_clear,
  input  wire logic [9:0]           i_wdt_preset,
  input  wire logic [NUM_TMR-1:0]   i_tmr_in,
  input  wire logic [NUM_TMR-1:0]   i_tmr_rst,
  input  wire logic [NUM_TMR*3-1:0] i_tmr_mode,
  input  wire logic [NUM_TMR*16-1:0] i_tmr_preset,
  input  wire logic [NUM_CNT-1:0]   i_cnt_count,
  input  wire logic [NUM_CNT-1:0]   i_cnt_down,
  input  wire logic [NUM_CNT-1:0]   i_cnt_rst,
  input  wire logic [NUM_CNT*2-1:0] i_cnt_mode,
  input  wire logic [NUM_CNT*16-1:0] i_cnt_preset,
  output wire logic [NUM_TMR-1:0]   o_tmr_q,
  output wire logic [NUM_TMR*16-1:0] o_tmr_cur,
  output wire logic [NUM_CNT-1:0]   o_cnt_q,
  output wire logic [NUM_CNT*16-1:0] o_cnt_cur,
  output logic      [15:0]          o_max_scan_time_flag,
  output logic      [15:0]          o_min_scan_time_flag,
  output logic      [15:0]          o_current_scan_time_flag,
  output logic                      o_wdt_error,
  output logic                      o_halted,
  output logic                      o_restart_pulse
);

  function automatic stcw_pkg::time_base_e base_of(input int idx);
    if (idx >= int'(`STCW_FIRST_1MS)) begin
      return stcw_pkg::TB_1MS;
    end else if (idx >= int'(`STCW_FIRST_10MS)) begin
      return stcw_pkg::TB_10MS;
    end
    return stcw_pkg::TB_100MS;
  endfunction

  // prescaler and supervision state
  logic [31:0] pre_cnt, next_pre_cnt;
  logic [3:0]  div10, next_div10;
  logic [3:0]  div100, next_div100;
  logic [2:0]  ticks, next_ticks;
  logic [3:0]  dip_ms, next_dip_ms;
  logic        next_halted;
  logic        next_restart;
  logic [12:0] wdt_ms, next_wdt_ms;
  logic [12:0] wdt_limit;
  logic [9:0]  wdt_pre;
  logic        next_wdt_error;
  logic [15:0] scan_ms, next_scan_ms, scan_now;
  logic        scan_seen, next_scan_seen;
  logic [15:0] next_max, next_min, next_curf;
  logic        off;
  logic        srst;

  assign off  = o_halted | o_wdt_error;
  assign srst = o_restart_pulse;

  always_comb begin
    // ticks index by time base: bit0 100 ms, bit1 10 ms, bit2 1 ms
    next_pre_cnt = pre_cnt + 32'h0000_0001;
    next_div10   = div10;
    next_div100  = div100;
    next_ticks   = 3'h0;
    if (pre_cnt >= 32'(CYC_PER_MS - 1)) begin
      next_pre_cnt = 32'h0000_0000;
      next_ticks[2] = 1'b1;
      next_div10 = div10 + 4'h1;
      if (div10 == `STCW_TB_DIV) begin
        next_div10 = 4'h0;
        next_ticks[1] = 1'b1;
        next_div100 = div100 + 4'h1;
        if (div100 == `STCW_TB_DIV) begin
          next_div100 = 4'h0;
          next_ticks[0] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    next_dip_ms  = dip_ms;
    next_halted  = o_halted;
    next_restart = i_restart;
    if (!i_power_ok) begin
      if (ticks[2] && dip_ms <= `STCW_DIP_MAX_MS) begin
        next_dip_ms = dip_ms + 4'h1;
      end
      if (dip_ms > `STCW_DIP_MAX_MS) begin
        next_halted = 1'b1;
      end
    end else begin
      next_dip_ms = 4'h0;
      if (o_halted) begin
        next_halted  = 1'b0;
        next_restart = 1'b1;
      end
    end
  end

  always_comb begin
    wdt_pre = i_wdt_preset;
    if (wdt_pre < `STCW_WDT_MIN) begin
      wdt_pre = `STCW_WDT_MIN;
    end else if (wdt_pre > `STCW_WDT_MAX) begin
      wdt_pre = `STCW_WDT_MAX;
    end
    wdt_limit   = 13'(wdt_pre * `STCW_WDT_STEP_MS);
    next_wdt_ms = wdt_ms;
    if (srst || i_mode_stop || i_wdt_clear || i_scan_start) begin
      next_wdt_ms = 13'h0000;
    end else if (ticks[2] && wdt_ms <= wdt_limit) begin
      next_wdt_ms = wdt_ms + 13'h0001;
    end
    next_wdt_error = o_wdt_error;
    if (srst || i_mode_stop) begin
      next_wdt_error = 1'b0;
    end
    if (!o_halted && !srst && wdt_ms > wdt_limit) begin
      next_wdt_error = 1'b1;
    end
  end

  always_comb begin
    // a tick landing on step zero still belongs to the scan that ends
    scan_now       = scan_ms;
    if (ticks[2] && scan_ms != 16'hFFFF) begin
      scan_now = scan_ms + 16'h0001;
    end
    next_scan_ms   = scan_ms;
    next_scan_seen = scan_seen;
    next_max       = o_max_scan_time_flag;
    next_min       = o_min_scan_time_flag;
    next_curf      = o_current_scan_time_flag;
    if (srst) begin
      next_scan_ms   = 16'h0000;
      next_scan_seen = 1'b0;
      next_max       = 16'h0000;
      next_min       = `STCW_MIN_INIT;
      next_curf      = 16'h0000;
    end else if (i_scan_start) begin
      next_scan_ms   = 16'h0000;
      next_scan_seen = 1'b1;
      if (scan_seen) begin
        next_curf = scan_now;
        if (scan_now > o_max_scan_time_flag) begin
          next_max = scan_now;
        end
        if (scan_now < o_min_scan_time_flag) begin
          next_min = scan_now;
        end
      end
    end else if (ticks[2] && scan_ms != 16'hFFFF) begin
      next_scan_ms = scan_ms + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_cnt                  <= 32'h0000_0000;
      div10                    <= 4'h0;
      div100                   <= 4'h0;
      ticks                    <= 3'h0;
      dip_ms                   <= 4'h0;
      o_halted                 <= 1'b0;
      o_restart_pulse          <= 1'b0;
      wdt_ms                   <= 13'h0000;
      o_wdt_error              <= 1'b0;
      scan_ms                  <= 16'h0000;
      scan_seen                <= 1'b0;
      o_max_scan_time_flag     <= 16'h0000;
      o_min_scan_time_flag     <= `STCW_MIN_INIT;
      o_current_scan_time_flag <= 16'h0000;
    end else begin
      pre_cnt                  <= next_pre_cnt;
      div10                    <= next_div10;
      div100                   <= next_div100;
      ticks                    <= next_ticks;
      dip_ms                   <= next_dip_ms;
      o_halted                 <= next_halted;
      o_restart_pulse          <= next_restart;
      wdt_ms                   <= next_wdt_ms;
      o_wdt_error              <= next_wdt_error;
      scan_ms                  <= next_scan_ms;
      scan_seen                <= next_scan_seen;
      o_max_scan_time_flag     <= next_max;
      o_min_scan_time_flag     <= next_min;
      o_current_scan_time_flag <= next_curf;
    end
  end

  // timer bank
  for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
    logic [15:0]           cur, next_cur, pre;
    logic                  q, next_q, prev_in, next_prev_in, tk, rise;
    stcw_pkg::timer_mode_e tm;

    always_comb begin
      tm   = stcw_pkg::timer_mode_e'(i_tmr_mode[g*3 +: 3]);
      pre  = i_tmr_preset[g*16 +: 16];
      tk   = ticks[base_of(g)];
      rise = i_tmr_in[g] & ~prev_in;
      next_cur     = cur;
      next_q       = q;
      next_prev_in = i_tmr_in[g];
      if (off || srst) begin
        next_cur     = 16'h0000;
        next_q       = 1'b0;
        next_prev_in = 1'b0;
      end else if (i_tmr_rst[g]) begin
        next_cur = 16'h0000;
        next_q   = 1'b0;
      end else begin
        case (tm)
          stcw_pkg::ON_DELAY_TIMER: begin
            if (i_tmr_in[g]) begin
              if (tk && cur < pre) begin
                next_cur = cur + 16'h0001;
              end
              next_q = (next_cur == pre);
            end else begin
              next_cur = 16'h0000;
              next_q   = 1'b0;
            end
          end
          stcw_pkg::OFF_DELAY_TIMER: begin
            if (i_tmr_in[g]) begin
              next_cur = 16'h0000;
              next_q   = 1'b1;
            end else if (q) begin
              if (tk) begin
                next_cur = cur + 16'h0001;
              end
              if (next_cur >= pre) begin
                next_q = 1'b0;
              end
            end
          end
          stcw_pkg::ACCUMULATING_TIMER: begin
            if (i_tmr_in[g] && tk && cur < pre) begin
              next_cur = cur + 16'h0001;
            end
            next_q = q | (next_cur == pre);
          end
          stcw_pkg::ONE_SHOT_TIMER, stcw_pkg::RETRIGGER_TIMER: begin
            if (rise && (!q || tm == stcw_pkg::RETRIGGER_TIMER)) begin
              next_cur = 16'h0000;
              next_q   = 1'b1;
            end else if (q && tk) begin
              next_cur = cur + 16'h0001;
              if (next_cur >= pre) begin
                next_cur = 16'h0000;
                next_q   = 1'b0;
              end
            end
          end
          default: begin
            next_cur = 16'h0000;
            next_q   = 1'b0;
          end
        endcase
      end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        cur     <= 16'h0000;
        q       <= 1'b0;
        prev_in <= 1'b0;
      end else begin
        cur     <= next_cur;
        q       <= next_q;
        prev_in <= next_prev_in;
      end
    end

    assign o_tmr_q[g]           = q;
    assign o_tmr_cur[g*16 +: 16] = cur;
  end

  // counter bank
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    logic [15:0]             cur, next_cur, pre;
    logic                    q, next_q, pu, pd, next_pu, next_pd, ru, rd;
    stcw_pkg::counter_mode_e cm;

    always_comb begin
      cm  = stcw_pkg::counter_mode_e'(i_cnt_mode[g*2 +: 2]);
      pre = i_cnt_preset[g*16 +: 16];
      ru  = i_cnt_count[g] & ~pu;
      rd  = i_cnt_down[g] & ~pd;
      next_pu  = i_cnt_count[g];
      next_pd  = i_cnt_down[g];
      next_cur = cur;
      next_q   = q;
      if (off || srst) begin
        next_cur = 16'h0000;
        next_q   = 1'b0;
        next_pu  = 1'b0;
        next_pd  = 1'b0;
      end else if (i_cnt_rst[g]) begin
        next_q   = 1'b0;
        next_cur = (cm == stcw_pkg::DOWN_COUNTER) ? pre : 16'h0000;
      end else begin
        case (cm)
          stcw_pkg::UP_COUNTER: begin
            if (ru && cur != 16'hFFFF) begin
              next_cur = cur + 16'h0001;
            end
            next_q = q | (next_cur == pre);
          end
          stcw_pkg::DOWN_COUNTER: begin
            if (ru && cur != 16'h0000) begin
              next_cur = cur - 16'h0001;
            end
            next_q = (next_cur == 16'h0000);
          end
          stcw_pkg::BIDIRECTIONAL_COUNTER: begin
            if (ru && !rd && cur != 16'hFFFF) begin
              next_cur = cur + 16'h0001;
            end else if (rd && !ru && cur != 16'h0000) begin
              next_cur = cur - 16'h0001;
            end
            next_q = (next_cur >= pre);
          end
          stcw_pkg::RING_COUNTER: begin
            if (ru) begin
              if (q) begin
                next_cur = 16'h0000;
                next_q   = 1'b0;
              end else begin
                next_cur = cur + 16'h0001;
                next_q   = (next_cur == pre);
              end
            end
          end
          default: begin
            next_cur = 16'h0000;
            next_q   = 1'b0;
          end
        endcase
      end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        cur <= 16'h0000;
        q   <= 1'b0;
        pu  <= 1'b0;
        pd  <= 1'b0;
      end else begin
        cur <= next_cur;
        q   <= next_q;
        pu  <= next_pu;
        pd  <= next_pd;
      end
    end

    assign o_cnt_q[g]            = q;
    assign o_cnt_cur[g*16 +: 16] = cur;
  end

endmodule // scan_timer_counter_watchdog

`default_nettype wire

// File: test/scan_timer_counter_watchdog_sva.sv
`timescale 1ns/1ps
`default_nettype none

module stcw_checker #(
  parameter int NUM_TMR    = 256,
  parameter int NUM_CNT    = 256,
  parameter int CYC_PER_MS = 200000
) (
  input wire logic                  i_clk_sys,
  input wire logic                  i_arst_n,
  input wire logic                  i_power_ok,
  input wire logic                  i_restart,
  input wire logic                  i_mode_stop,
  input wire logic [NUM_CNT-1:0]    i_cnt_count,
  input wire logic [NUM_CNT-1:0]    i_cnt_down,
  input wire logic [NUM_CNT-1:0]    i_cnt_rst,
  input wire logic [NUM_TMR-1:0]    o_tmr_q,
  input wire logic [NUM_CNT-1:0]    o_cnt_q,
  input wire logic [NUM_CNT*16-1:0] o_cnt_cur,
  input wire logic [15:0]           o_max_scan_time_flag,
  input wire logic [15:0]           o_min_scan_time_flag,
  input wire logic [15:0]           o_current_scan_time_flag,
  input wire logic                  o_wdt_error,
  input wire logic                  o_halted,
  input wire logic                  o_restart_pulse
);
  localparam int DIP_MIN = 10 * CYC_PER_MS;
  localparam int DIP_MAX = 12 * CYC_PER_MS + 3;
  logic [31:0] low_cnt;
  logic [31:0] next_low_cnt;

  // length of the present supply dip in clocks
  always_comb next_low_cnt = i_power_ok ? 32'h0 : low_cnt + 32'h1;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) low_cnt <= 32'h0;
    else low_cnt <= next_low_cnt;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_halt_off; o_halted |=> o_tmr_q == '0 && o_cnt_q == '0; endproperty
  a_halt_off: assert property (p_halt_off)
    else $error("outputs on while halted");
  property p_halt_early; $rose(o_halted) |-> low_cnt >= DIP_MIN; endproperty
  a_halt_early: assert property (p_halt_early)
    else $error("halt on a short dip");
  property p_halt_late; low_cnt > DIP_MAX |-> o_halted; endproperty
  a_halt_late: assert property (p_halt_late)
    else $error("no halt on a long dip");
  property p_power_back; o_halted && i_power_ok |=> o_restart_pulse; endproperty
  a_power_back: assert property (p_power_back)
    else $error("no restart on power return");
  property p_wdt_off; o_wdt_error |=> o_tmr_q == '0 && o_cnt_q == '0; endproperty
  a_wdt_off: assert property (p_wdt_off)
    else $error("outputs on during watchdog error");
  property p_wdt_sticky;
    o_wdt_error && !i_mode_stop && !i_restart && !o_restart_pulse
      |=> o_wdt_error;
  endproperty
  a_wdt_sticky: assert property (p_wdt_sticky)
    else $error("watchdog error dropped");
  property p_restart_clr;
    o_restart_pulse |=> !o_wdt_error && o_max_scan_time_flag == 16'h0000
      && o_min_scan_time_flag == 16'hFFFF;
  endproperty
  a_restart_clr: assert property (p_restart_clr)
    else $error("state kept over restart");
  property p_stat_order;
    $changed(o_current_scan_time_flag)
      |=> o_current_scan_time_flag <= o_max_scan_time_flag;
  endproperty
  a_stat_order: assert property (p_stat_order)
    else $error("current scan above maximum");
  property p_cnt_level;
    i_cnt_count[0] && $past(i_cnt_count[0]) && !i_cnt_down[0] && !i_cnt_rst[0]
      && !o_restart_pulse && !o_wdt_error && !o_halted
      && !$past(o_restart_pulse) && !$past(o_wdt_error) && !$past(o_halted)
      |=> $stable(o_cnt_cur[15:0]);
  endproperty
  a_cnt_level: assert property (p_cnt_level)
    else $error("counter moved on a level");
endmodule // stcw_checker

bind scan_timer_counter_watchdog stcw_checker #(
  .NUM_TMR(NUM_TMR), .NUM_CNT(NUM_CNT), .CYC_PER_MS(CYC_PER_MS)
) stcw_checker_i (
  .i_clk_sys, .i_arst_n, .i_power_ok, .i_restart, .i_mode_stop, .i_cnt_count,
  .i_cnt_down, .i_cnt_rst, .o_tmr_q, .o_cnt_q, .o_cnt_cur, .o_wdt_error,
  .o_max_scan_time_flag, .o_min_scan_time_flag, .o_current_scan_time_flag,
  .o_halted, .o_restart_pulse
);

`default_nettype wire

// File: test/scan_program_model.sv
`timescale 1ns/1ps
`default_nettype none

module scan_program_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_run,
  input  wire logic       i_scan_on,
  input  wire logic [7:0] i_period,
  output logic            o_scan_start,
  output logic            o_wdt_clear
);
  logic [7:0] cnt = 8'h00;

  initial o_scan_start = 1'b0;
  initial o_wdt_clear = 1'b0;

  // step zero once a period; clear issued at each period head, scans on or off
  always @(negedge i_clk_sys) begin
    o_scan_start <= i_run && i_scan_on && cnt == 8'h00;
    o_wdt_clear <= i_run && cnt == 8'h00;
    cnt <= (!i_run || cnt >= i_period - 8'h01) ? 8'h00 : cnt + 8'h01;
  end
endmodule // scan_program_model

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int NT = 256;
  localparam int NC = 4;
  localparam int B = 251;
  localparam int T10 = 250;
  localparam int T100 = 191;
  logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_power_ok = 1'b1;
  logic i_restart = 1'b0, i_mode_stop = 1'b0, i_scan_start, i_wdt_clear;
  logic [9:0] i_wdt_preset = 10'h000;
  logic [NT-1:0] i_tmr_in = '0, i_tmr_rst = '0, o_tmr_q;
  logic [NT*3-1:0] i_tmr_mode = '0;
  logic [NT*16-1:0] i_tmr_preset = '0, o_tmr_cur;
  logic [NC-1:0] i_cnt_count = '0, i_cnt_down = '0, i_cnt_rst = '0, o_cnt_q;
  logic [NC*2-1:0] i_cnt_mode = 8'hE4;
  logic [NC*16-1:0] i_cnt_preset = 64'h0002_0002_0002_0002, o_cnt_cur;
  logic [15:0] o_max_scan_time_flag, o_min_scan_time_flag;
  logic [15:0] o_current_scan_time_flag;
  logic o_wdt_error, o_halted, o_restart_pulse;
  logic run = 1'b0, scan_on = 1'b1;
  logic [7:0] period = 8'h32;
  int errors = 0;
  int tests_run = 0;
  logic [63:0] cx [6] = '{64'h0000_0000_0002_0000, 64'h0001_0001_0001_0001,
    64'h0002_0002_0000_0002, 64'h0000_0003_0000_0003,
    64'h0000_0002_0000_0003, 64'h0000_0001_0000_0003};
  logic [3:0] qx [6] = '{4'h0, 4'h0, 4'hF, 4'h7, 4'h7, 4'h3};

  scan_timer_counter_watchdog #(.NUM_TMR(NT), .NUM_CNT(NC), .CYC_PER_MS(10))
  scan_timer_counter_watchdog_i (.i_clk_sys, .i_arst_n, .i_power_ok,
    .i_restart, .i_mode_stop, .i_scan_start, .i_wdt_clear, .i_wdt_preset,
    .i_tmr_in, .i_tmr_rst, .i_tmr_mode, .i_tmr_preset, .i_cnt_count,
    .i_cnt_down, .i_cnt_rst, .i_cnt_mode, .i_cnt_preset, .o_tmr_q, .o_tmr_cur,
    .o_cnt_q, .o_cnt_cur, .o_max_scan_time_flag, .o_min_scan_time_flag,
    .o_current_scan_time_flag, .o_wdt_error, .o_halted, .o_restart_pulse);
  scan_program_model scan_program_model_i (.i_clk_sys, .i_run(run),
    .i_scan_on(scan_on), .i_period(period), .o_scan_start(i_scan_start),
    .o_wdt_clear(i_wdt_clear));

  initial forever #2.5 i_clk_sys = ~i_clk_sys;

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic tq(input logic [4:0] exp);
    chk("timer outputs", {11'h000, exp}, {11'h000, o_tmr_q[B+:5]});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_counters();
    for (int s = 0; s < 6; s++) begin
      if (s == 0) i_cnt_rst = 4'hF;
      else if (s < 4) i_cnt_count = 4'hF;
      else i_cnt_down = 4'h4;
      cyc(3);
      {i_cnt_rst, i_cnt_count, i_cnt_down} = 12'h000;
      cyc(2);
      chk("counter q", {12'h000, qx[s]}, {12'h000, o_cnt_q});
      for (int c = 0; c < NC; c++)
        chk("counter value", cx[s][c*16+:16], o_cnt_cur[c*16+:16]);
    end
    $display("counters done");
  endtask

  task automatic t_timers();
    i_tmr_in[B+:5] = 5'h1F;
    {i_tmr_in[T10], i_tmr_in[T100]} = 2'h3;
    cyc(2);
    tq(5'h1A);
    cyc(8);
    i_tmr_in[B+1] = 1'b0;
    cyc(10);
    i_tmr_in[B+2+:3] = 3'h0;
    cyc(10);
    i_tmr_in[B+3+:2] = 2'h3;
    cyc(5);
    tq(5'h1A);
    chk("10 ms base", 16'h0000, {15'h0000, o_tmr_q[T10]});
    cyc(15);
    i_tmr_in[B+2] = 1'b1;
    cyc(16);
    tq(5'h11);
    chk("one-shot value", 16'h0000, o_tmr_cur[(B+3)*16+:16]);
    cyc(44);
    tq(5'h05);
    chk("retrigger value", 16'h0000, o_tmr_cur[(B+4)*16+:16]);
    i_tmr_in[B+:5] = 5'h00;
    cyc(15);
    tq(5'h04);
    chk("on-delay value", 16'h0000, o_tmr_cur[B*16+:16]);
    chk("10 ms base", 16'h0001, {15'h0000, o_tmr_q[T10]});
    chk("100 ms base", 16'h0000, {15'h0000, o_tmr_q[T100]});
    i_tmr_rst[B+2] = 1'b1;
    cyc(2);
    i_tmr_rst[B+2] = 1'b0;
    tq(5'h00);
    $display("timers done");
  endtask

  task automatic t_scan_stats();
    chk("max scan", 16'h0005, o_max_scan_time_flag);
    chk("min scan", 16'h0005, o_min_scan_time_flag);
    period <= 8'h1E;
    cyc(150);
    chk("current scan", 16'h0003, o_current_scan_time_flag);
    chk("min scan", 16'h0003, o_min_scan_time_flag);
    chk("max scan", 16'h0005, o_max_scan_time_flag);
    $display("scan statistics done");
  endtask

  task automatic t_watchdog();
    scan_on <= 1'b0;
    i_tmr_in[B+1] = 1'b1;
    cyc(300);
    chk("error with clears", 16'h0000, {15'h0000, o_wdt_error});
    run <= 1'b0;
    cyc(65);
    chk("error early", 16'h0000, {15'h0000, o_wdt_error});
    cyc(65);
    chk("error raised", 16'h0001, {15'h0000, o_wdt_error});
    tq(5'h00);
    run <= 1'b1;
    cyc(3);
    chk("error after clear", 16'h0001, {15'h0000, o_wdt_error});
    i_mode_stop = 1'b1;
    cyc(2);
    i_mode_stop = 1'b0;
    cyc(2);
    chk("error after stop", 16'h0000, {15'h0000, o_wdt_error});
    i_tmr_in[B+1] = 1'b0;
    scan_on <= 1'b1;
    $display("watchdog done");
  endtask

  task automatic t_power();
    i_tmr_in[B] = 1'b1;
    cyc(80);
    i_power_ok = 1'b0;
    cyc(80);
    i_power_ok = 1'b1;
    cyc(2);
    chk("short dip halt", 16'h0000, {15'h0000, o_halted});
    tq(5'h01);
    i_power_ok = 1'b0;
    cyc(140);
    chk("long dip halt", 16'h0001, {15'h0000, o_halted});
    tq(5'h00);
    i_power_ok = 1'b1;
    cyc(3);
    chk("halt after return", 16'h0000, {15'h0000, o_halted});
    chk("min after restart", 16'hFFFF, o_min_scan_time_flag);
    cyc(100);
    i_restart = 1'b1;
    cyc(1);
    i_restart = 1'b0;
    cyc(3);
    chk("max after restart", 16'h0000, o_max_scan_time_flag);
    chk("100 ms base", 16'h0000, {15'h0000, o_tmr_q[T100]});
    cyc(850);
    chk("100 ms base", 16'h0001, {15'h0000, o_tmr_q[T100]});
    $display("power done");
  endtask

  // whole run is near 2000 clocks
  initial begin
    #50000;
    errors++;
    conclude();
  end

  initial begin
    for (int k = 0; k < 5; k++) begin
      i_tmr_mode[(B+k)*3+:3] = 3'(k);
      i_tmr_preset[(B+k)*16+:16] = 16'h0005;
    end
    i_tmr_preset[T10*16+:16] = 16'h0001;
    i_tmr_preset[T100*16+:16] = 16'h0001;
    cyc(8);
    i_arst_n = 1'b1;
    run <= 1'b1;
    cyc(2);
    t_counters();
    t_timers();
    t_scan_stats();
    t_watchdog();
    t_power();
    conclude();
  end
endmodule // tb_top

`default_nettype wire
